// ===== verilog/tsc_pkg.sv
// constants and types for the thermometer standby and serial control block
// Contract
// - in standby the converter stays idle unless a permitted one-shot arrives
// - standby is entered by low standby pin or by the halt bit set
// - both standby modes keep registers and keep the serial slave answering
// - in pin standby a one-shot command starts no conversion
// - in halt standby a one-shot command runs exactly one conversion
// - low standby pin overrides continuous runs and one-shot requests
// - standby arriving mid-conversion aborts it; both results stay unchanged
// - a conversion lasts 125 ms, then the rate timer sets the idle gap
// - results, status and settings appear to the host as byte registers
// - both channels answer on one shared slave address
// - only write byte, read byte, send byte and receive byte are used
// - receive byte returns the register named by the stored command byte
// - readings are sign plus seven bits, two's complement, 1 degree, msb first
// - a half degree is added before truncation, rounding to nearest degree
// - every conversion covers both channels and updates both results at end
// - a busy status bit shows a conversion; old results stay readable
package tsc_pkg;
	localparam int          CLK_MHZ    = 200;
	localparam int          CONV_MS    = 125;
	localparam logic [31:0] CONV_CYC   = 32'(CONV_MS * CLK_MHZ * 1000);
	localparam int          PER_MS     = 2000;
	localparam logic [31:0] PER_CYC    = 32'(PER_MS * CLK_MHZ * 1000);
	localparam logic [6:0]  SLV_ADDR   = 7'h18;
	localparam logic [7:0]  CMD_LOC    = 8'h00;
	localparam logic [7:0]  CMD_REM    = 8'h01;
	localparam logic [7:0]  CMD_STAT   = 8'h02;
	localparam logic [7:0]  CMD_CFG_RD = 8'h03;
	localparam logic [7:0]  CMD_RAT_RD = 8'h04;
	localparam logic [7:0]  CMD_CFG_WR = 8'h09;
	localparam logic [7:0]  CMD_RAT_WR = 8'h0a;
	localparam logic [7:0]  CMD_ONESHOT = 8'h0f;
	localparam int          CFG_HALT   = 6;
	localparam int          STAT_BUSY  = 7;
	localparam logic [7:0]  CFG_RST    = 8'h00;
	localparam logic [2:0]  RATE_RST   = 3'h2;
	localparam logic [7:0]  TEMP_RST   = 8'h00;
	localparam logic [7:0]  CMD_RST    = 8'h00;
	localparam logic [10:0] ROUND_OFS  = 11'h002;
	localparam logic [7:0]  TEMP_MAX   = 8'h7f;
	localparam logic [7:0]  TEMP_MIN   = 8'hbf;
	localparam logic [3:0]  BITS_BYTE  = 4'h8;

	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_CONV = 2'b01,
		C_WAIT = 2'b10
	} tsc_cst_t;

	typedef enum logic [2:0] {
		B_IDLE = 3'b000,
		B_RX   = 3'b001,
		B_ACK  = 3'b010,
		B_TX   = 3'b011,
		B_MACK = 3'b100
	} tsc_bst_t;

	typedef enum logic [1:0] {
		P_ADDR = 2'b00,
		P_CMD  = 2'b01,
		P_DATA = 2'b10
	} tsc_phase_t;

	// raw readings in quarter degrees, signed
	typedef struct packed {
		logic [10:0] loc;
		logic [10:0] rem;
	} tsc_adc_t;

	typedef struct packed {
		logic busy;
		logic standby;
	} tsc_stat_t;
endpackage : tsc_pkg

// ===== verilog/tsc_conv.sv
// conversion sequencer with rate timer and standby gating
`timescale 1ns/1ps
module tsc_conv #(
	parameter logic [31:0] CONV_CYC = tsc_pkg::CONV_CYC,
	parameter logic [31:0] PER_CYC  = tsc_pkg::PER_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// control
	input  wire logic       hw_sb,
	input  wire logic       halt,
	input  wire logic       halt_rise,
	input  wire logic       oneshot,
	input  wire logic [2:0] rate,
	// status
	output logic            busy,
	output logic            done
);
	tsc_pkg::tsc_cst_t st, next_st;
	logic [31:0]       cnt, next_cnt;
	logic              next_busy, next_done;
	logic              abort;

	assign abort = hw_sb | halt_rise;

	always_comb
	begin
		next_st   = st;
		next_cnt  = cnt;
		next_done = 1'b0;
		unique case (st)
			tsc_pkg::C_IDLE:
			begin
				if (!hw_sb && (oneshot || !halt))
				begin
					next_st  = tsc_pkg::C_CONV;
					next_cnt = 32'h0;
				end
			end
			tsc_pkg::C_CONV:
			begin
				if (abort)
					next_st = tsc_pkg::C_IDLE;
				else if (cnt == CONV_CYC - 32'h1)
				begin
					next_done = 1'b1;
					next_cnt  = 32'h0;
					next_st   = halt ? tsc_pkg::C_IDLE : tsc_pkg::C_WAIT;
				end
				else
					next_cnt = cnt + 32'h1;
			end
			tsc_pkg::C_WAIT:
			begin
				next_cnt = cnt + 32'h1;
				if (hw_sb || halt)
					next_st = tsc_pkg::C_IDLE;
				else if (oneshot || cnt >= (PER_CYC >> rate) - 32'h1)
				begin
					next_st  = tsc_pkg::C_CONV;
					next_cnt = 32'h0;
				end
			end
			default:
				next_st = tsc_pkg::C_IDLE;
		endcase
		next_busy = (next_st == tsc_pkg::C_CONV);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			st   <= tsc_pkg::C_IDLE;
			cnt  <= 32'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			st   <= next_st;
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_idle_no_conv: assert property (st == tsc_pkg::C_IDLE && (hw_sb || (halt && !oneshot))
		|=> !busy) else $error("conversion began in standby");
	a_pin_blocks: assert property (hw_sb |=> !busy && st == tsc_pkg::C_IDLE)
		else $error("conversion ran with standby pin low");
	a_abort_nodone: assert property (busy && abort |=> !done && !busy)
		else $error("aborted conversion still completed");
	a_oneshot_run: assert property (st == tsc_pkg::C_IDLE && halt && !hw_sb && oneshot
		|=> busy) else $error("one-shot did not start conversion");
	a_done_ends: assert property (done |-> !busy && $past(busy, 1))
		else $error("done without a conversion");
	a_conv_len: assert property (done |-> $past(cnt, 1) == CONV_CYC - 32'h1)
		else $error("conversion length wrong");
	c_abort: cover property (busy ##1 abort ##1 !busy);
	c_oneshot: cover property (halt && oneshot && st == tsc_pkg::C_IDLE ##1 busy);
endmodule : tsc_conv

// ===== verilog/tsc_top.sv
// thermometer control: standby, conversion gating, serial slave registers
`timescale 1ns/1ps
module tsc_top #(
	parameter logic [31:0] CONV_CYC = tsc_pkg::CONV_CYC,
	parameter logic [31:0] PER_CYC  = tsc_pkg::PER_CYC
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// standby pin
	input  wire logic               hw_standby_n,
	// serial link
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output logic                    sda_out,
	output logic                    sda_oe_n,
	// converter
	input  wire tsc_pkg::tsc_adc_t  adc,
	output tsc_pkg::tsc_stat_t      stat
);
	logic [2:0]          sync1, sync2;
	logic                scl_q, sda_q;
	logic                scl_s, sda_s, hw_standby_n_n_s;
	logic                scl_rise, scl_fall, bus_start, bus_stop;
	tsc_pkg::tsc_bst_t   bst, next_bst;
	tsc_pkg::tsc_phase_t phase, next_phase;
	logic [3:0]          bcnt, next_bcnt;
	logic [7:0]          shreg, next_shreg;
	logic [7:0]          txb, next_txb;
	logic                rd, next_rd;
	logic                byte_rdy, next_byte_rdy;
	logic                nack, next_nack;
	logic                next_sda_oe_n;
	logic                oneshot, next_oneshot;
	logic [7:0]          cmd, next_cmd;
	logic [7:0]          cfg, next_cfg;
	logic [2:0]          rate, next_rate;
	logic [7:0]          t_loc, next_t_loc;
	logic [7:0]          t_rem, next_t_rem;
	logic                halt_q;
	logic                hw_sb, halt, halt_rise;
	logic                conv_busy, conv_done;
	tsc_pkg::tsc_stat_t  next_stat;

	// add half degree, truncate, clamp to the reportable span
	function automatic logic [7:0] conv_temp(input logic [10:0] raw);
		logic [11:0] sum;
		logic [9:0]  q;
		sum = {raw[10], raw} + {1'b0, tsc_pkg::ROUND_OFS};
		q   = sum[11:2];
		if (!q[9] && q[8:7] != 2'b00)
			conv_temp = tsc_pkg::TEMP_MAX;
		else if (q[9] && $signed(q) < $signed({{2{1'b1}}, tsc_pkg::TEMP_MIN}))
			conv_temp = tsc_pkg::TEMP_MIN;
		else
			conv_temp = q[7:0];
	endfunction : conv_temp

	// register read decode
	function automatic logic [7:0] rd_reg(input logic [7:0] c);
		unique case (c)
			tsc_pkg::CMD_LOC:    rd_reg = t_loc;
			tsc_pkg::CMD_REM:    rd_reg = t_rem;
			tsc_pkg::CMD_STAT:   rd_reg = {conv_busy, 7'h00};
			tsc_pkg::CMD_CFG_RD: rd_reg = cfg;
			tsc_pkg::CMD_RAT_RD: rd_reg = {5'h00, rate};
			default:             rd_reg = 8'h00;
		endcase
	endfunction : rd_reg

	// two-stage synchronisers for pins
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sync1  <= 3'h7;
			sync2  <= 3'h7;
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			halt_q <= 1'b0;
		end
		else
		begin
			sync1  <= {hw_standby_n, sda_in, scl_in};
			sync2  <= sync1;
			scl_q  <= scl_s;
			sda_q  <= sda_s;
			halt_q <= halt;
		end
	end

	assign scl_s     = sync2[0];
	assign sda_s     = sync2[1];
	assign hw_standby_n_n_s  = sync2[2];
	assign scl_rise  = scl_s & ~scl_q;
	assign scl_fall  = ~scl_s & scl_q;
	assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
	assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
	assign hw_sb     = ~hw_standby_n_n_s;
	assign halt      = cfg[tsc_pkg::CFG_HALT];
	assign halt_rise = halt & ~halt_q;

	tsc_conv #(
		.CONV_CYC (CONV_CYC),
		.PER_CYC  (PER_CYC)
	) u_conv (
		.clk       (clk),
		.rstn      (rstn),
		.hw_sb     (hw_sb),
		.halt      (halt),
		.halt_rise (halt_rise),
		.oneshot   (oneshot),
		.rate      (rate),
		.busy      (conv_busy),
		.done      (conv_done)
	);

	// serial slave, live in every mode
	always_comb
	begin
		next_bst      = bst;
		next_phase    = phase;
		next_bcnt     = bcnt;
		next_shreg    = shreg;
		next_txb      = txb;
		next_rd       = rd;
		next_byte_rdy = byte_rdy;
		next_nack     = nack;
		next_sda_oe_n = sda_oe_n;
		next_oneshot  = 1'b0;
		next_cmd      = cmd;
		next_cfg      = cfg;
		next_rate     = rate;
		if (bus_stop)
		begin
			next_bst      = tsc_pkg::B_IDLE;
			next_sda_oe_n = 1'b1;
		end
		else if (bus_start)
		begin
			next_bst      = tsc_pkg::B_RX;
			next_phase    = tsc_pkg::P_ADDR;
			next_bcnt     = 4'h0;
			next_byte_rdy = 1'b0;
			next_sda_oe_n = 1'b1;
		end
		else
		begin
			unique case (bst)
				tsc_pkg::B_IDLE:
					next_sda_oe_n = 1'b1;
				tsc_pkg::B_RX:
				begin
					if (scl_rise)
					begin
						next_shreg = {shreg[6:0], sda_s};
						next_bcnt  = bcnt + 4'h1;
						if (bcnt == tsc_pkg::BITS_BYTE - 4'h1)
							next_byte_rdy = 1'b1;
					end
					else if (scl_fall && byte_rdy)
					begin
						next_byte_rdy = 1'b0;
						next_sda_oe_n = 1'b0;
						next_bst      = tsc_pkg::B_ACK;
						unique case (phase)
							tsc_pkg::P_ADDR:
							begin
								if (shreg[7:1] == tsc_pkg::SLV_ADDR)
								begin
									next_rd    = shreg[0];
									next_phase = tsc_pkg::P_CMD;
								end
								else
								begin
									next_sda_oe_n = 1'b1;
									next_bst      = tsc_pkg::B_IDLE;
								end
							end
							tsc_pkg::P_CMD:
							begin
								next_cmd   = shreg;
								next_phase = tsc_pkg::P_DATA;
								if (shreg == tsc_pkg::CMD_ONESHOT)
									next_oneshot = 1'b1;
							end
							default:
							begin
								if (cmd == tsc_pkg::CMD_CFG_WR)
									next_cfg = shreg;
								else if (cmd == tsc_pkg::CMD_RAT_WR)
									next_rate = shreg[2:0];
							end
						endcase
					end
				end
				tsc_pkg::B_ACK:
				begin
					if (scl_fall)
					begin
						next_bcnt = 4'h0;
						if (rd)
						begin
							next_txb      = rd_reg(cmd);
							next_sda_oe_n = next_txb[7];
							next_bst      = tsc_pkg::B_TX;
						end
						else
						begin
							next_sda_oe_n = 1'b1;
							next_bst      = tsc_pkg::B_RX;
						end
					end
				end
				tsc_pkg::B_TX:
				begin
					if (scl_rise)
						next_bcnt = bcnt + 4'h1;
					else if (scl_fall)
					begin
						if (bcnt == tsc_pkg::BITS_BYTE)
						begin
							next_sda_oe_n = 1'b1;
							next_bst      = tsc_pkg::B_MACK;
						end
						else
						begin
							next_txb      = {txb[6:0], 1'b0};
							next_sda_oe_n = txb[6];
						end
					end
				end
				tsc_pkg::B_MACK:
				begin
					if (scl_rise)
						next_nack = sda_s;
					else if (scl_fall)
					begin
						if (nack)
							next_bst = tsc_pkg::B_IDLE;
						else
						begin
							next_bcnt     = 4'h0;
							next_txb      = rd_reg(cmd);
							next_sda_oe_n = next_txb[7];
							next_bst      = tsc_pkg::B_TX;
						end
					end
				end
				default:
					next_bst = tsc_pkg::B_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			bst      <= tsc_pkg::B_IDLE;
			phase    <= tsc_pkg::P_ADDR;
			bcnt     <= 4'h0;
			shreg    <= 8'h00;
			txb      <= 8'h00;
			rd       <= 1'b0;
			byte_rdy <= 1'b0;
			nack     <= 1'b0;
			sda_oe_n <= 1'b1;
			sda_out  <= 1'b0;
			oneshot  <= 1'b0;
			cmd      <= tsc_pkg::CMD_RST;
			cfg      <= tsc_pkg::CFG_RST;
			rate     <= tsc_pkg::RATE_RST;
		end
		else
		begin
			bst      <= next_bst;
			phase    <= next_phase;
			bcnt     <= next_bcnt;
			shreg    <= next_shreg;
			txb      <= next_txb;
			rd       <= next_rd;
			byte_rdy <= next_byte_rdy;
			nack     <= next_nack;
			sda_oe_n <= next_sda_oe_n;
			sda_out  <= 1'b0;
			oneshot  <= next_oneshot;
			cmd      <= next_cmd;
			cfg      <= next_cfg;
			rate     <= next_rate;
		end
	end

	// results latch only at a completed conversion
	always_comb
	begin
		next_t_loc = conv_done ? conv_temp(adc.loc) : t_loc;
		next_t_rem = conv_done ? conv_temp(adc.rem) : t_rem;
		next_stat.busy    = conv_busy;
		next_stat.standby = hw_sb | halt;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			t_loc <= tsc_pkg::TEMP_RST;
			t_rem <= tsc_pkg::TEMP_RST;
			stat  <= '0;
		end
		else
		begin
			t_loc <= next_t_loc;
			t_rem <= next_t_rem;
			stat  <= next_stat;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_hw_standby_n_sync: assert property (!hw_standby_n [*4] |-> stat.standby && !conv_busy)
		else $error("standby pin not honoured");
	a_keep_temp: assert property (!conv_done |=> $stable(t_loc) && $stable(t_rem))
		else $error("result changed without conversion");
	a_round_res: assert property (conv_done |=> t_loc == conv_temp($past(adc.loc))
		&& t_rem == conv_temp($past(adc.rem))) else $error("result not rounded");
	a_addr_ack: assert property (bst == tsc_pkg::B_RX && byte_rdy && scl_fall && !bus_stop
		&& !bus_start && phase == tsc_pkg::P_ADDR && shreg[7:1] == tsc_pkg::SLV_ADDR
		|=> !sda_oe_n) else $error("own address not acknowledged");
	a_recv_cmd: assert property (bst == tsc_pkg::B_ACK && scl_fall && rd && !bus_stop
		&& !bus_start |=> txb == $past(rd_reg(cmd))) else $error("wrong register sent");
	c_read_ack: cover property (bst == tsc_pkg::B_MACK ##1 bst == tsc_pkg::B_IDLE);
	c_done: cover property (conv_done);
endmodule : tsc_top

// ===== dv/tsc_host.sv
// serial bus host model that clocks the link and drives the data wire open-drain
`timescale 1ns/1ps
module tsc_host (
	// serial link
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	localparam int HALF = 24;
	// clock stands high between frames, data released to the pull-up
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start_cond();
		if (scl === 1'b0)
		begin
			#2 sda_low = 1'b0;
			#(HALF - 2) scl = 1'b1;
		end
		#HALF sda_low = 1'b1;
		#HALF scl = 1'b0;
	endtask : start_cond
	task automatic stop_cond();
		#2 sda_low = 1'b1;
		#(HALF - 2) scl = 1'b1;
		#HALF sda_low = 1'b0;
		#HALF;
	endtask : stop_cond
	// data changes only while clock is low, sampled at end of high phase
	task automatic bit_io(input logic b, output logic got);
		#2 sda_low = ~b;
		#(HALF - 2) scl = 1'b1;
		#HALF got = sda;
		scl = 1'b0;
	endtask : bit_io
	// msb first, then the ack bit from the slave
	task automatic put_byte(input logic [7:0] d, output logic ack_n);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], g);
		bit_io(1'b1, ack_n);
	endtask : put_byte
	// single master here, so the short protocols are safe
	task automatic get_byte(input logic nack, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, g);
	endtask : get_byte
endmodule : tsc_host

// ===== dv/tsc_top_tb.sv
// self-checking bench for the thermometer control block
`timescale 1ns/1ps
module tsc_top_tb;
	localparam int      CV  = 600;
	localparam int      PER = 800;
	localparam int      GAP = 200;
	logic               clk;
	logic               rstn;
	logic               hw_standby_n;
	logic               scl;
	logic               sda_low;
	logic               sda_out;
	logic               sda_oe_n;
	wire logic          sda_wire;
	tsc_pkg::tsc_adc_t  adc;
	tsc_pkg::tsc_stat_t stat;
	int                 n_fail;
	int                 checked;
	int                 cyc;
	int                 cur_l;
	int                 cur_r;
	int                 n;
	logic [7:0]         exp_l;
	logic [7:0]         exp_r;
	logic [7:0]         rd;
	int                 raws [8] = '{508, 600, 506, -2, -3, -100, -280, 101};
	assign sda_wire = (sda_oe_n | sda_out) & ~sda_low;
	tsc_top #(.CONV_CYC(32'(CV)), .PER_CYC(32'(PER))) dut (
		.clk(clk), .rstn(rstn), .hw_standby_n(hw_standby_n),
		.scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.adc(adc), .stat(stat));
	tsc_host host (.scl(scl), .sda_low(sda_low), .sda(sda_wire));
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	// reference rounding: half degree offset, floor, clamp
	function automatic logic [7:0] rnd(input int raw);
		int v;
		v = (raw + 2) >>> 2;
		if (v > 127)
			v = 127;
		if (v < -65)
			v = -65;
		return 8'(v);
	endfunction : rnd
	// kind 0 write byte, 1 read byte, 2 send byte, 3 receive byte
	task automatic xfer(input int k, input logic [7:0] cmd, input logic [7:0] wd,
		output logic [7:0] r);
		logic [2:0] a;
		a = 3'h0;
		host.start_cond();
		if (k != 3)
		begin
			host.put_byte({tsc_pkg::SLV_ADDR, 1'b0}, a[0]);
			host.put_byte(cmd, a[1]);
			if (k == 0)
				host.put_byte(wd, a[2]);
			if (k == 1)
				host.start_cond();
		end
		if (k[0])
		begin
			host.put_byte({tsc_pkg::SLV_ADDR, 1'b1}, a[2]);
			host.get_byte(1'b1, r);
		end
		host.stop_cond();
		chk({5'h0, a}, 8'h00, "acknowledge");
	endtask : xfer
	task automatic wait_busy(input logic lvl, input int lim, output int k);
		k = 0;
		while (stat.busy !== lvl && k < lim)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		if (k == lim)
			chk(8'h00, 8'h01, "busy wait");
	endtask : wait_busy
	task automatic cnt_rise(input int lim, output int k);
		logic prev;
		k = 0;
		prev = stat.busy;
		repeat (lim)
		begin
			@(posedge clk);
			#1;
			if (stat.busy === 1'b1 && prev !== 1'b1)
				k++;
			prev = stat.busy;
		end
	endtask : cnt_rise
	task automatic set_adc(input int l, input int r);
		@(posedge clk);
		adc <= {11'(l), 11'(r)};
		cur_l = l;
		cur_r = r;
	endtask : set_adc
	task automatic conv();
		int k;
		wait_busy(1'b0, CV + 10, k);
		wait_busy(1'b1, GAP + 10, k);
		wait_busy(1'b0, CV + 10, k);
		exp_l = rnd(cur_l);
		exp_r = rnd(cur_r);
	endtask : conv
	task automatic rd_chk();
		logic [7:0] r;
		xfer(1, tsc_pkg::CMD_LOC, 8'h00, r);
		chk(r, exp_l, "local reading");
		xfer(1, tsc_pkg::CMD_REM, 8'h00, r);
		chk(r, exp_r, "remote reading");
		xfer(3, 8'h00, 8'h00, r);
		chk(r, exp_r, "receive byte");
	endtask : rd_chk
	initial
	begin
		void'($urandom(32'hd1895523));
		rstn = 1'b0;
		hw_standby_n = 1'b1;
		adc = '0;
		set_adc(101, -100);
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		wait_busy(1'b1, 20, n);
		wait_busy(1'b0, CV + 10, n);
		chk({7'h0, n >= CV - 1 && n <= CV + 1}, 8'h01, "conversion length");
		wait_busy(1'b1, GAP + 10, n);
		chk({7'h0, n >= GAP - 1 && n <= GAP + 1}, 8'h01, "idle gap");
		exp_l = rnd(cur_l);
		exp_r = rnd(cur_r);
		rd_chk();
		for (int i = 0; i < 10; i++)
		begin
			if (i < 8)
				set_adc(raws[i], raws[7 - i]);
			else
				set_adc(int'($signed(11'($urandom))), int'($signed(11'($urandom))));
			conv();
			rd_chk();
		end
		// halt arriving mid-conversion
		wait_busy(1'b0, CV + 10, n);
		set_adc(300, -250);
		wait_busy(1'b1, GAP + 10, n);
		xfer(0, tsc_pkg::CMD_CFG_WR, 8'h40, rd);
		wait_busy(1'b0, 20, n);
		chk({7'h0, stat.standby}, 8'h01, "halt standby");
		rd_chk();
		cnt_rise(1000, n);
		chk(8'(n), 8'h00, "halted conversions");
		xfer(1, tsc_pkg::CMD_CFG_RD, 8'h00, rd);
		chk(rd, 8'h40, "config kept");
		xfer(1, tsc_pkg::CMD_STAT, 8'h00, rd);
		chk(rd & 8'h80, 8'h00, "idle status");
		fork
			xfer(2, tsc_pkg::CMD_ONESHOT, 8'h00, rd);
			cnt_rise(1000, n);
		join
		chk(8'(n), 8'h01, "one-shot in halt");
		exp_l = rnd(cur_l);
		exp_r = rnd(cur_r);
		rd_chk();
		// pin standby overrides one-shot and continuous run
		@(posedge clk);
		hw_standby_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk({7'h0, stat.standby}, 8'h01, "pin standby");
		fork
			xfer(2, tsc_pkg::CMD_ONESHOT, 8'h00, rd);
			cnt_rise(1000, n);
		join
		chk(8'(n), 8'h00, "one-shot in pin standby");
		fork
			xfer(0, tsc_pkg::CMD_CFG_WR, 8'h00, rd);
			cnt_rise(1000, n);
		join
		chk(8'(n), 8'h00, "run under pin standby");
		chk({7'h0, stat.standby}, 8'h01, "pin standby alone");
		rd_chk();
		// pin falling mid-conversion
		set_adc(-50, 77);
		hw_standby_n <= 1'b1;
		wait_busy(1'b1, 20, n);
		repeat (20) @(posedge clk);
		hw_standby_n <= 1'b0;
		wait_busy(1'b0, 10, n);
		rd_chk();
		xfer(1, tsc_pkg::CMD_RAT_RD, 8'h00, rd);
		chk(rd, {5'h00, tsc_pkg::RATE_RST}, "rate after reset");
		xfer(0, tsc_pkg::CMD_RAT_WR, 8'h03, rd);
		xfer(1, tsc_pkg::CMD_RAT_RD, 8'h00, rd);
		chk(rd, 8'h03, "rate written");
		xfer(1, 8'h05, 8'h00, rd);
		chk(rd, 8'h00, "unknown command");
		host.start_cond();
		host.put_byte({tsc_pkg::SLV_ADDR ^ 7'h01, 1'b0}, rd[0]);
		host.stop_cond();
		chk({7'h0, rd[0]}, 8'h01, "foreign address");
		give_verdict();
	end
endmodule : tsc_top_tb
